/* common/standby_ctrl_defines.vh */
// role codes, register offset and timing for the supply standby controller
// assumes the management-bus engine is outside and hands over decoded byte accesses
// Functional notes
// R1: converter runs only when role needs it
// R2: pull wake line low on fault or undervoltage
// R3: standby supply turns on while wake low
// R4: turn-on compares load share to host threshold
// R5: active member drives wake high when healthy
// R6: no active driver high means everyone runs
// R7: converter on after reset
// R8: host sets an active member before standby
// R9: standby only when wake high, share low
// R10: threshold depends on standby position
// R11: example turn-on levels 3.2, 5.0, 6.7 V
// R12: example turn-off levels 1.44, 3.01, 4.52 V
// R13: 8.0 V load share is full power
// R14: turn on within 100 us of wake low
// R15: role is byte command d0 with pec
// R16: role 00 standard redundancy, power-on value
// R17: role 01 always-on active member
// R18: roles 02-04 standby positions one to three
// R19: role 05 always standby
// R20: wake falling edge reverts standby roles to 00
// R21: invalid role write rejected, flag set
// R22: wake input synchronised, single edge detected
`ifndef STANDBY_CTRL_DEFINES_VH
`define STANDBY_CTRL_DEFINES_VH
`define ROLE_CFG_CMD      8'hd0
`define ROLE_STANDARD     8'h00
`define ROLE_ACTIVE       8'h01
`define ROLE_STANDBY1     8'h02
`define ROLE_STANDBY2     8'h03
`define ROLE_STANDBY3     8'h04
`define ROLE_ALWAYS_SBY   8'h05
`define ROLE_RESET        8'h00
// load share codes: 8 bit adc, 255 = 8.0 V full scale
`define LS_FULL_MV        8000
`define LS_ON1_MV         3200
`define LS_ON2_MV         5000
`define LS_ON3_MV         6700
`define LS_OFF1_MV        1440
`define LS_OFF2_MV        3010
`define LS_OFF3_MV        4520
`define WAKE_ON_NS        100000
`define CLK_NS            8
`define CML_INVALID_BIT   6
`endif

/* verilog/standby_ctrl.v */
// per-supply standby controller for the efficiency redundancy group
// assumes an 8-bit load share sample on CLK and decoded byte writes/reads of command d0
`timescale 1ns/1ps
`include "standby_ctrl_defines.vh"
module standby_ctrl #(
  parameter LS_W = 8
) (
  input  wire            CLK,          // 125 MHz
  input  wire            SRST,         // sync reset, high
  input  wire            CMD_WR,       // one-cycle byte write strobe
  input  wire            CMD_RD,       // one-cycle byte read strobe
  input  wire [7:0]      CMD_CODE,     // command code
  input  wire [7:0]      CMD_WDATA,    // write byte
  output reg  [7:0]      CMD_RDATA,    // read byte
  output reg             CMD_ACK,      // access accepted
  output reg             CMD_NAK,      // access rejected
  input  wire [7:0]      CML_CLR,      // clear bits of comm status
  output reg  [7:0]      COMM_STATUS_FLAGS, // comm status
  input  wire [LS_W-1:0] LOAD_SHARE,   // load share sample, full scale 8.0 V
  input  wire            FAULT,        // internal fault (pin)
  input  wire            VOUT_LOW,     // vout below vfault (pin)
  input  wire            WAKE_IN,      // shared wake line level (pin)
  output reg             WAKE_OUT,     // wake line drive value
  output reg             WAKE_OE,      // wake line drive enable
  output reg             CONVERTER_ACTIVE_N, // low = main converter runs
  output reg  [7:0]      ROLE          // current role byte
);
  // overview of the run decision:
  // - roles 00 and 01 always run; role 05 rests whenever the wake line is high
  // - roles 02 to 04 follow the load share with a hysteresis band
  // - a low wake line forces every role to run, which also covers the case
  //   where no active member holds the line high
  // - the wake line is only ever driven low on a fault, or high by role 01

  // full-scale code of the load share sample stands for 8.0 V
  localparam integer FS_I   = (1 << LS_W) - 1; // R13
  localparam integer ON1_I  = (`LS_ON1_MV  * FS_I) / `LS_FULL_MV;
  localparam integer ON2_I  = (`LS_ON2_MV  * FS_I) / `LS_FULL_MV;
  localparam integer ON3_I  = (`LS_ON3_MV  * FS_I) / `LS_FULL_MV;
  localparam integer OFF1_I = (`LS_OFF1_MV * FS_I) / `LS_FULL_MV;
  localparam integer OFF2_I = (`LS_OFF2_MV * FS_I) / `LS_FULL_MV;
  localparam integer OFF3_I = (`LS_OFF3_MV * FS_I) / `LS_FULL_MV;

  // thresholds cut to the sample width; integer division rounds down
  localparam [LS_W-1:0] ON1  = ON1_I[LS_W-1:0];  // R11
  localparam [LS_W-1:0] ON2  = ON2_I[LS_W-1:0];  // R11
  localparam [LS_W-1:0] ON3  = ON3_I[LS_W-1:0];  // R11
  localparam [LS_W-1:0] OFF1 = OFF1_I[LS_W-1:0]; // R12
  localparam [LS_W-1:0] OFF2 = OFF2_I[LS_W-1:0]; // R12
  localparam [LS_W-1:0] OFF3 = OFF3_I[LS_W-1:0]; // R12

  // pin inputs that cross into CLK: fault, vout low and the wake line
  localparam PIN_N    = 3;
  localparam PIN_FLT  = 0;
  localparam PIN_VLOW = 1;
  localparam PIN_WAKE = 2;

  // synchronisers and history
  wire [PIN_N-1:0] pin_raw;
  wire [PIN_N-1:0] pin_sync;
  reg  [LS_W-1:0]  ls_s1_ff;
  reg  [LS_W-1:0]  ls_s2_ff;
  reg              wk_d_ff;
  reg              run_ff;

  // next values of the registered outputs
  reg  [7:0]       nxt_role;
  reg              nxt_run;
  reg              nxt_wake_out;
  reg              nxt_wake_oe;
  reg  [7:0]       nxt_flags;
  reg              nxt_ack;
  reg              nxt_nak;
  reg  [7:0]       nxt_rdata;

  assign pin_raw = {WAKE_IN, VOUT_LOW, FAULT};

  // command code decode, used by the read, write and status paths
  function role_cmd_hit;
    input [7:0] code;
    begin
      role_cmd_hit = (code == `ROLE_CFG_CMD); // R15
    end
  endfunction

  // only the six defined role values are accepted
  function valid_role;
    input [7:0] v;
    begin
      valid_role = (v <= `ROLE_ALWAYS_SBY); // R21
    end
  endfunction

  // true for the three load-following standby positions
  function standby_pos;
    input [7:0] r;
    begin
      standby_pos = (r == `ROLE_STANDBY1) ||
                    (r == `ROLE_STANDBY2) ||
                    (r == `ROLE_STANDBY3); // R18
    end
  endfunction

  // enable level by standby position; other roles never look at it
  function [LS_W-1:0] on_level;
    input [7:0] r;
    begin
      if (r == `ROLE_STANDBY3)
        on_level = ON3;
      else if (r == `ROLE_STANDBY2)
        on_level = ON2;
      else
        on_level = ON1; // R10
    end
  endfunction

  // disable level by standby position, always below the enable level
  function [LS_W-1:0] off_level;
    input [7:0] r;
    begin
      if (r == `ROLE_STANDBY3)
        off_level = OFF3;
      else if (r == `ROLE_STANDBY2)
        off_level = OFF2;
      else
        off_level = OFF1; // R10
    end
  endfunction

  wire            wr_hit;
  wire            rd_hit;
  wire            wr_ok;
  wire            wr_bad;
  wire            is_sby;
  wire [LS_W-1:0] th_on;
  wire [LS_W-1:0] th_off;
  wire            fault_now;
  wire            wake_sync;
  wire            wake_fall;

  assign wr_hit    = CMD_WR & role_cmd_hit(CMD_CODE);
  assign rd_hit    = CMD_RD & role_cmd_hit(CMD_CODE);
  assign wr_ok     = wr_hit & valid_role(CMD_WDATA);  // R15
  assign wr_bad    = wr_hit & ~valid_role(CMD_WDATA); // R21
  assign is_sby    = standby_pos(ROLE);
  assign th_on     = on_level(ROLE);  // R4
  assign th_off    = off_level(ROLE); // R12
  assign fault_now = pin_sync[PIN_FLT] | pin_sync[PIN_VLOW]; // R2
  assign wake_sync = pin_sync[PIN_WAKE];
  // the delay flop resets low, so leaving reset never fakes a fall
  assign wake_fall = wk_d_ff & ~wake_sync; // R22

  // two flops per pin; only the second flop is read by any logic
  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi = gi + 1) begin : g_pin_sync
      reg s1_ff;
      reg s2_ff;
      always @(posedge CLK) begin
        if (SRST) begin
          s1_ff <= 1'b0;
          s2_ff <= 1'b0;
        end else begin
          s1_ff <= pin_raw[gi];
          s2_ff <= s1_ff;
        end
      end
      assign pin_sync[gi] = s2_ff; // R22
    end
  endgenerate

  // load share is handled like a pin; a code caught mid-change is at worst
  // one sample late, which the hysteresis band absorbs
  always @(posedge CLK) begin
    if (SRST) begin
      ls_s1_ff <= {LS_W{1'b0}};
      ls_s2_ff <= {LS_W{1'b0}};
      wk_d_ff  <= 1'b0;
    end else begin
      ls_s1_ff <= LOAD_SHARE;
      ls_s2_ff <= ls_s1_ff;
      wk_d_ff  <= wake_sync;
    end
  end

  // role register: host writes, and a wake fall drops standby roles
  always @* begin
    nxt_role = ROLE;
    if (wr_ok)
      nxt_role = CMD_WDATA; // R15 R17 R19
    // edge reversion of a current standby role wins over a write in the same cycle
    if (wake_fall && is_sby)
      nxt_role = `ROLE_STANDARD; // R20
  end

  // run decision by role; the wake line overrides it at the end
  always @* begin
    nxt_run = 1'b1; // R1
    case (ROLE)
      `ROLE_STANDARD: begin
        nxt_run = 1'b1; // R16
      end
      `ROLE_ACTIVE: begin
        nxt_run = 1'b1; // R17
      end
      `ROLE_ALWAYS_SBY: begin
        nxt_run = 1'b0; // R19
      end
      `ROLE_STANDBY1, `ROLE_STANDBY2, `ROLE_STANDBY3: begin
        if (ls_s2_ff > th_on)
          nxt_run = 1'b1; // R4 R9
        else if (ls_s2_ff < th_off)
          nxt_run = 1'b0; // R9
        else
          nxt_run = run_ff; // hold inside the band
      end
      default: begin
        nxt_run = 1'b1;
      end
    endcase
    // low wake also stands for "no active member drives high"
    if (!wake_sync)
      nxt_run = 1'b1; // R3 R6
  end

  // healthy active member drives high; every role pulls low on a fault
  always @* begin
    nxt_wake_out = 1'b0;
    nxt_wake_oe  = 1'b0; // R16 R18
    if (fault_now) begin
      nxt_wake_out = 1'b0; // R2
      nxt_wake_oe  = 1'b1;
    end else if (ROLE == `ROLE_ACTIVE) begin
      nxt_wake_out = 1'b1; // R5 R17
      nxt_wake_oe  = 1'b1;
    end
  end

  // bus answer: one-cycle ack or nak, read data held until the next read
  always @* begin
    nxt_ack   = 1'b0;
    nxt_nak   = 1'b0;
    nxt_rdata = CMD_RDATA;
    if (rd_hit) begin
      nxt_ack   = 1'b1;
      nxt_rdata = ROLE; // R15
    end else if (wr_hit) begin
      nxt_ack = wr_ok;
      nxt_nak = wr_bad; // R21
    end
  end

  // sticky status; a new invalid write beats a clear in the same cycle
  always @* begin
    nxt_flags = COMM_STATUS_FLAGS & ~CML_CLR;
    if (wr_bad)
      nxt_flags[`CML_INVALID_BIT] = 1'b1; // R21
  end

  // converter and role state; reset leaves the converter running
  always @(posedge CLK) begin
    if (SRST) begin
      ROLE               <= `ROLE_RESET; // R16
      run_ff             <= 1'b1;
      CONVERTER_ACTIVE_N <= 1'b0; // R7
    end else begin
      ROLE               <= nxt_role;
      run_ff             <= nxt_run;
      // two sync flops plus this one: a few cycles, far inside the budget
      CONVERTER_ACTIVE_N <= ~nxt_run; // R9 R14
    end
  end

  // wake line drive; enable high only while this supply drives the line
  always @(posedge CLK) begin
    if (SRST) begin
      WAKE_OUT <= 1'b0;
      WAKE_OE  <= 1'b0;
    end else begin
      WAKE_OUT <= nxt_wake_out;
      WAKE_OE  <= nxt_wake_oe;
    end
  end

  // management bus answer and status
  always @(posedge CLK) begin
    if (SRST) begin
      CMD_RDATA         <= 8'h00;
      CMD_ACK           <= 1'b0;
      CMD_NAK           <= 1'b0;
      COMM_STATUS_FLAGS <= 8'h00;
    end else begin
      CMD_RDATA         <= nxt_rdata;
      CMD_ACK           <= nxt_ack;
      CMD_NAK           <= nxt_nak;
      COMM_STATUS_FLAGS <= nxt_flags;
    end
  end
endmodule

/* test/standby_ctrl_properties.sv */
// assertions on the standby controller ports
// assumes a bind onto standby_ctrl, one clock domain
`timescale 1ns/1ps
module standby_ctrl_properties #(parameter LS_W = 8) (
  input wire logic CLK, SRST, CMD_WR, CMD_RD, CMD_ACK, CMD_NAK, FAULT, VOUT_LOW,
  input wire logic WAKE_IN, WAKE_OUT, WAKE_OE, CONVERTER_ACTIVE_N,
  input wire logic [7:0] CMD_CODE, CMD_WDATA, CMD_RDATA, COMM_STATUS_FLAGS, ROLE,
  input wire logic [LS_W-1:0] LOAD_SHARE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  wire hit = CMD_CODE == 8'hd0;
  wire ok = !FAULT && !VOUT_LOW;
  a_bad_nak: assert property (CMD_WR && hit && CMD_WDATA > 8'h05
    |=> CMD_NAK && COMM_STATUS_FLAGS[6]) else $error("no nak");
  a_read_back: assert property (CMD_RD && !CMD_WR && hit
    |=> CMD_ACK && CMD_RDATA == $past(ROLE)) else $error("bad read");
  a_reset_on: assert property ($fell(SRST)
    |-> !CONVERTER_ACTIVE_N && ROLE == 8'h00 && !WAKE_OE) else $error("bad reset");
  a_fault_pull: assert property (!ok [*3] |=> WAKE_OE && !WAKE_OUT) else $error("no pull");
  a_active_high: assert property ((ok && ROLE == 8'h01) [*4]
    |-> WAKE_OE && WAKE_OUT) else $error("no drive");
  a_wake_run: assert property (!WAKE_IN [*4] |-> !CONVERTER_ACTIVE_N) else $error("off");
  a_load_sleep: assert property ((ROLE == 8'h02 && WAKE_IN && LOAD_SHARE < 8'd45) [*4]
    |-> CONVERTER_ACTIVE_N) else $error("no sleep");
  a_edge_revert: assert property ($fell(WAKE_IN) && ROLE >= 8'h02 && ROLE <= 8'h04
    |-> ##[1:3] ROLE == 8'h00) else $error("no revert");
  cover property (CMD_NAK);
  cover property (CONVERTER_ACTIVE_N);
  cover property ($fell(WAKE_IN) && ROLE == 8'h03);
endmodule
bind standby_ctrl standby_ctrl_properties #(.LS_W(LS_W)) u_props (.*);

/* test/wake_peer.sv */
// peer supply on the shared wake line, open drain with pull-up
// assumes the bench commands the peer's fault pull
`timescale 1ns/1ps
module wake_peer (
  input  wire logic PULL, // peer fault pull
  input  wire logic OE,   // device drive enable
  input  wire logic OUT,  // device drive value
  output wire logic LINE  // resolved level
);
  // the peer stands for an active member, so standby is allowed
  // a low driver wins; a high driver reads the same as the pull-up
  assign LINE = !(PULL || (OE && !OUT));
endmodule

/* test/standby_ctrl_tb_top.sv */
// bench for the standby controller with one peer on the wake line
// assumes the design, peer model and checker are compiled first
`timescale 1ns/1ps
module standby_ctrl_tb_top;
  logic CLK = 0, SRST = 1, CMD_WR = 0, CMD_RD = 0, FAULT = 0, VOUT_LOW = 0, pull = 0;
  logic [7:0] CMD_CODE = 8'hd0, CMD_WDATA = 0, CML_CLR = 0, LOAD_SHARE = 0;
  wire [7:0] CMD_RDATA, COMM_STATUS_FLAGS, ROLE;
  wire CMD_ACK, CMD_NAK, WAKE_OUT, WAKE_OE, CONVERTER_ACTIVE_N, WAKE_IN;
  int errors = 0, checks_done = 0;
  standby_ctrl #(.LS_W(8)) u_dut (
    .CLK(CLK), .SRST(SRST), .CMD_WR(CMD_WR), .CMD_RD(CMD_RD), .CMD_CODE(CMD_CODE),
    .CMD_WDATA(CMD_WDATA), .CMD_RDATA(CMD_RDATA), .CMD_ACK(CMD_ACK), .CMD_NAK(CMD_NAK),
    .CML_CLR(CML_CLR), .COMM_STATUS_FLAGS(COMM_STATUS_FLAGS), .LOAD_SHARE(LOAD_SHARE),
    .FAULT(FAULT), .VOUT_LOW(VOUT_LOW), .WAKE_IN(WAKE_IN), .WAKE_OUT(WAKE_OUT),
    .WAKE_OE(WAKE_OE), .CONVERTER_ACTIVE_N(CONVERTER_ACTIVE_N), .ROLE(ROLE));
  wake_peer u_peer (.PULL(pull), .OE(WAKE_OE), .OUT(WAKE_OUT), .LINE(WAKE_IN));
  initial forever #4 CLK = ~CLK;
  // about 35 times the expected run
  initial begin #40000; errors++; close_out; end
  task chk(input logic c, input string m);
    checks_done++;
    if (!c) begin errors++; $display("CHECK FAILED %0t %s", $time, m); end
  endtask
  task close_out;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task cyc(input int n); repeat (n) @(negedge CLK); endtask
  task bus(input logic w, input logic [7:0] d, input logic k);
    CMD_WR = w;
    CMD_RD = !w;
    CMD_WDATA = d;
    cyc(1);
    chk(CMD_ACK === k && CMD_NAK === (w & !k), "answer");
    CMD_WR = 0;
    CMD_RD = 0;
    cyc(1);
  endtask
  task t_roles;
    for (int r = 5; r >= 0; r--) begin
      bus(1, r[7:0], 1); bus(0, 0, 1); chk(CMD_RDATA === r[7:0], "read");
    end
    bus(1, 8'h06, 0);
    chk(COMM_STATUS_FLAGS[6] === 1'b1 && ROLE === 8'h00, "invalid");
    CML_CLR = 8'h40; cyc(2); CML_CLR = 0;
    chk(COMM_STATUS_FLAGS[6] === 1'b0, "clear");
    $display("t_roles done");
  endtask
  task t_levels;
    logic [7:0] on_c [3] = '{8'd102, 8'd159, 8'd213};
    logic [7:0] off_c [3] = '{8'd45, 8'd95, 8'd144};
    for (int p = 0; p < 3; p++) begin
      bus(1, 8'h02 + p[7:0], 1); LOAD_SHARE = off_c[p] - 8'd1; cyc(5);
      chk(CONVERTER_ACTIVE_N === 1'b1 && WAKE_OE === 1'b0, "sleep");
      LOAD_SHARE = on_c[p] + 8'd1; cyc(5);
      chk(CONVERTER_ACTIVE_N === 1'b0, "load on");
      LOAD_SHARE = off_c[p]; cyc(5);
      chk(CONVERTER_ACTIVE_N === 1'b0, "hold");
    end
    bus(1, 8'h05, 1); LOAD_SHARE = 8'hff; cyc(5);
    chk(CONVERTER_ACTIVE_N === 1'b1, "always standby");
    bus(1, 8'h01, 1); cyc(5);
    chk(CONVERTER_ACTIVE_N === 1'b0 && WAKE_OE === 1'b1 && WAKE_OUT === 1'b1, "active");
    $display("t_levels done");
  endtask
  task t_wake;
    bus(1, 8'h03, 1); LOAD_SHARE = 8'd10; cyc(5); pull = 1; cyc(4);
    chk(CONVERTER_ACTIVE_N === 1'b0 && ROLE === 8'h00, "wake");
    pull = 0; cyc(3); bus(1, 8'h03, 1); cyc(5);
    chk(ROLE === 8'h03 && CONVERTER_ACTIVE_N === 1'b1, "one edge");
    FAULT = 1; cyc(4);
    chk(WAKE_OE === 1'b1 && WAKE_OUT === 1'b0 && WAKE_IN === 1'b0, "fault");
    FAULT = 0; VOUT_LOW = 1; cyc(4);
    chk(WAKE_OE === 1'b1 && WAKE_OUT === 1'b0, "vout");
    VOUT_LOW = 0; cyc(5);
    chk(WAKE_OE === 1'b0, "float");
    $display("t_wake done");
  endtask
  initial begin
    cyc(16); SRST = 0; cyc(1);
    chk(ROLE === 8'h00 && CONVERTER_ACTIVE_N === 1'b0 && WAKE_OE === 1'b0, "reset");
    $display("t_reset done");
    t_roles;
    t_levels;
    t_wake;
    close_out;
  end
endmodule
